/* src/rtcsa_port.sv */
// rtc two-wire slave access port with pointer, register space and freeze
// Overview of operation
// - slave only; respond after start plus own address
// - twenty byte locations in fixed order
// - data change while clock high is control
// - start: data falls while clock high
// - stop: data rises while clock high
// - one clock pulse per bit, sampled high
// - eight-bit bytes plus ninth acknowledge pulse
// - start begins, stop ends, unlimited bytes
// - hold data low over acknowledge pulse
// - master nack ends read, line released
// - addressed read via repeated start
// - pointer advances only on acknowledge clock
// - reads continue while master acknowledges
// - freeze time copy while pointer in time
// - unfreeze on stop or non-time pointer
// - freeze applies to reads and writes
// - plain read starts at held pointer
// - first write byte loads pointer, then data
// - time write clears sub-second to zero
// - time write resets divider chain
`timescale 1ns/1ps
module rtcsa_port (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output rtcsa_pkg::rtcsa_pin_t sda_pin,
	input wire rtcsa_pkg::rtcsa_upd_t upd,
	output logic freeze,
	output logic div_reset,
	output rtcsa_pkg::rtcsa_regs_t regs_o
);
	import rtcsa_pkg::*;

	// complete state of the port
	typedef struct packed {
		rtcsa_state_t state;       // protocol phase
		logic [3:0] cnt;           // bits seen in this byte
		logic [7:0] shift;         // receive or transmit shifter
		logic rw;                  // direction bit of the address
		logic ack;                 // master acknowledged last byte
		logic [RTCSA_PW-1:0] ptr;  // register pointer
		logic oe;                  // pulling sda low
		logic freeze;              // time copy held
		logic div_reset;           // divider chain reset pulse
		logic scl_q;               // previous synced clock
		logic sda_q;               // previous synced data
		rtcsa_regs_t regs;         // user-visible register bytes
	} rtcsa_core_t;

	rtcsa_core_t s_reg;
	rtcsa_core_t s_next;

	logic scl_s;       // synced clock line
	logic sda_s;       // synced data line
	logic scl_rise;    // clock rising edge
	logic scl_fall;    // clock falling edge
	logic start_det;   // start condition seen
	logic stop_det;    // stop condition seen
	logic byte_done;   // falling edge ending the eighth bit

	// pointer lies in the timekeeping range
	function automatic logic is_time(input logic [RTCSA_PW-1:0] p);
		is_time = (p <= RTCSA_TIME_LAST);
	endfunction : is_time

	// next pointer value with wrap
	function automatic logic [RTCSA_PW-1:0] ptr_inc(
		input logic [RTCSA_PW-1:0] p);
		ptr_inc = (p >= RTCSA_LAST) ? RTCSA_PTR_RST : p + 5'h01;
	endfunction : ptr_inc

	// phase in which an addressed transfer is in progress
	function automatic logic is_active(input rtcsa_state_t st);
		is_active = (st != ST_IDLE) && (st != ST_IGNORE) &&
			(st != ST_ADDR);
	endfunction : is_active

	// pins cross into the clock domain through two flops
	rtcsa_sync #(
		.W(2)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.din({scl_i, sda_i}),
		.dout({scl_s, sda_s})
	);

	// edge and bus condition detection on synced lines
	assign scl_rise = scl_s & ~s_reg.scl_q;
	assign scl_fall = ~scl_s & s_reg.scl_q;
	assign start_det = scl_s & s_reg.scl_q & s_reg.sda_q & ~sda_s;
	assign stop_det = scl_s & s_reg.scl_q & ~s_reg.sda_q & sda_s;
	assign byte_done = scl_fall && (s_reg.cnt == RTCSA_BYTE_BITS);

	// next-state logic of the whole port
	always_comb begin
		s_next = s_reg;
		s_next.div_reset = 1'b0;
		s_next.scl_q = scl_s;
		s_next.sda_q = sda_s;
		// time copy loads only when not frozen
		if (upd.stb && !s_reg.freeze) begin
			s_next.regs[RTCSA_NTIME-1:0] = upd.tval;
		end
		case (s_reg.state)
			// receiving states share the bit shifter
			ST_ADDR, ST_WADDR, ST_WDATA: begin
				if (scl_rise) begin
					s_next.shift = {s_reg.shift[6:0], sda_s};
					s_next.cnt = s_reg.cnt + 4'h1;
				end
				if (byte_done) begin
					s_next.cnt = 4'h0;
					if (s_reg.state == ST_ADDR) begin
						if (s_reg.shift[7:1] == RTCSA_SLAVE_ADDR) begin
							s_next.rw = s_reg.shift[0];
							s_next.oe = 1'b1;
							s_next.state = ST_AACK;
						end else begin
							s_next.state = ST_IGNORE;
						end
					end else if (s_reg.state == ST_WADDR) begin
						s_next.ptr = (s_reg.shift < RTCSA_NREG) ?
							s_reg.shift[RTCSA_PW-1:0] : RTCSA_PTR_RST;
						s_next.oe = 1'b1;
						s_next.state = ST_WAACK;
					end else begin
						s_next.regs[s_reg.ptr] = s_reg.shift;
						if (is_time(s_reg.ptr)) begin
							s_next.regs[RTCSA_SUBSEC] = RTCSA_SUBSEC_WR;
						end
						s_next.oe = 1'b1;
						s_next.state = ST_WDACK;
					end
				end
			end
			// address acknowledged, choose direction
			ST_AACK: begin
				if (scl_fall) begin
					s_next.cnt = 4'h0;
					if (s_reg.rw) begin
						s_next.shift = s_reg.regs[s_reg.ptr];
						s_next.oe = ~s_reg.regs[s_reg.ptr][7];
						s_next.state = ST_RDATA;
					end else begin
						s_next.oe = 1'b0;
						s_next.state = ST_WADDR;
					end
				end
			end
			// word address acknowledged
			ST_WAACK: begin
				if (scl_fall) begin
					s_next.oe = 1'b0;
					s_next.state = ST_WDATA;
				end
			end
			// data byte acknowledged, pointer moves
			ST_WDACK: begin
				if (scl_fall) begin
					s_next.ptr = ptr_inc(s_reg.ptr);
					s_next.div_reset = is_time(s_reg.ptr);
					s_next.oe = 1'b0;
					s_next.state = ST_WDATA;
				end
			end
			// shifting a byte out, msb first
			ST_RDATA: begin
				if (scl_rise) begin
					s_next.cnt = s_reg.cnt + 4'h1;
				end
				if (byte_done) begin
					s_next.oe = 1'b0;
					s_next.state = ST_RACK;
				end else if (scl_fall) begin
					s_next.shift = {s_reg.shift[6:0], 1'b0};
					s_next.oe = ~s_reg.shift[6];
				end
			end
			// master acknowledge slot
			ST_RACK: begin
				if (scl_rise) begin
					s_next.ack = ~sda_s;
					s_next.ptr = ptr_inc(s_reg.ptr);
				end
				if (scl_fall) begin
					s_next.cnt = 4'h0;
					if (s_reg.ack) begin
						s_next.shift = s_reg.regs[s_reg.ptr];
						s_next.oe = ~s_reg.regs[s_reg.ptr][7];
						s_next.state = ST_RDATA;
					end else begin
						s_next.state = ST_IGNORE;
					end
				end
			end
			// idle or not addressed: line stays released
			ST_IDLE, ST_IGNORE: begin
				s_next.oe = 1'b0;
			end
			default: begin
				s_next.oe = 1'b0;
				s_next.state = ST_IDLE;
			end
		endcase
		// stop ends, start (also repeated) begins
		if (stop_det) begin
			s_next.oe = 1'b0;
			s_next.state = ST_IDLE;
		end else if (start_det) begin
			s_next.oe = 1'b0;
			s_next.cnt = 4'h0;
			s_next.state = ST_ADDR;
		end
		// freeze in any direction; once set it
		// survives repeated start and nack, only stop or a non-time pointer
		// lets updates through again
		s_next.freeze = is_time(s_next.ptr) && (is_active(s_next.state) ||
			(s_reg.freeze && s_next.state != ST_IDLE));
	end

	// register the whole port state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_reg.state <= ST_IDLE;
			s_reg.cnt <= 4'h0;
			s_reg.shift <= RTCSA_BYTE_RST;
			s_reg.rw <= 1'b0;
			s_reg.ack <= 1'b0;
			s_reg.ptr <= RTCSA_PTR_RST;
			s_reg.oe <= 1'b0;
			s_reg.freeze <= 1'b0;
			s_reg.div_reset <= 1'b0;
			s_reg.scl_q <= RTCSA_BUS_IDLE;
			s_reg.sda_q <= RTCSA_BUS_IDLE;
			s_reg.regs <= {RTCSA_NREG{RTCSA_BYTE_RST}};
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from flops, except the data level, which is tied low
	assign sda_pin.o = 1'b0;
	assign sda_pin.oe = s_reg.oe;
	assign freeze = s_reg.freeze;
	assign div_reset = s_reg.div_reset;
	assign regs_o = s_reg.regs;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// start always leads to address phase
	AST_START_ADDR: assert property (
		start_det && !stop_det |=> s_reg.state == ST_ADDR && !s_reg.oe)
		else $error("start not followed by address phase");
	// stop returns to idle and lifts the freeze
	AST_STOP_IDLE: assert property (
		stop_det |=> s_reg.state == ST_IDLE && !s_reg.freeze)
		else $error("stop did not end transfer");
	// own address is acknowledged by pulling low
	AST_ADDR_ACK: assert property (
		s_reg.state == ST_ADDR && byte_done && !start_det && !stop_det &&
		s_reg.shift[7:1] == RTCSA_SLAVE_ADDR
		|=> s_reg.state == ST_AACK && sda_pin.oe)
		else $error("own address not acknowledged");
	// foreign address leaves the line alone
	AST_ADDR_IGNORE: assert property (
		s_reg.state == ST_ADDR && byte_done && !start_det && !stop_det &&
		s_reg.shift[7:1] != RTCSA_SLAVE_ADDR
		|=> s_reg.state == ST_IGNORE ##1 !sda_pin.oe)
		else $error("foreign address acknowledged");
	// freeze only while the pointer is in time range
	AST_FREEZE_RANGE: assert property (
		s_reg.freeze |-> s_reg.ptr <= RTCSA_TIME_LAST)
		else $error("freeze outside time range");
	// frozen copy ignores core updates
	AST_FREEZE_HOLD: assert property (
		s_reg.freeze && upd.stb && s_reg.state == ST_RDATA
		|=> $stable(s_reg.regs[RTCSA_TIME_LAST:0]))
		else $error("time copy changed while frozen");
	// pointer advances by one with wrap in the ack slot
	AST_PTR_STEP: assert property (
		s_reg.state == ST_RACK && scl_rise && !stop_det && !start_det
		|=> s_reg.ptr == ((($past(s_reg.ptr)) >= RTCSA_LAST) ?
			RTCSA_PTR_RST : $past(s_reg.ptr) + 5'h01))
		else $error("pointer step wrong");
	// write to a time byte clears the sub-second byte
	AST_SUBSEC_CLR: assert property (
		s_reg.state == ST_WDATA && byte_done && !stop_det &&
		!start_det && s_reg.ptr <= RTCSA_TIME_LAST
		|=> s_reg.regs[RTCSA_SUBSEC] == RTCSA_SUBSEC_WR)
		else $error("sub-second not cleared");
	// completed time write pulses divider reset once
	AST_DIV_RESET: assert property (
		s_reg.state == ST_WDACK && scl_fall && !stop_det && !start_det &&
		s_reg.ptr <= RTCSA_TIME_LAST |=> div_reset ##1 !div_reset)
		else $error("divider reset missing");
	// nack at end of read releases the line
	AST_NACK_RELEASE: assert property (
		s_reg.state == ST_RACK && scl_fall && !s_reg.ack &&
		!start_det && !stop_det |=> s_reg.state == ST_IGNORE && !sda_pin.oe)
		else $error("line held after master nack");

	// main scenarios
	COV_READ: cover property (s_reg.state == ST_RACK ##1
		s_reg.state == ST_RDATA);
	// the divider pulse shows once the data ack slot has been left
	COV_WRITE: cover property (s_reg.state == ST_WDATA && div_reset);
	COV_FOREIGN: cover property (s_reg.state == ST_IGNORE && stop_det);
	COV_WRAP: cover property (s_reg.ptr == RTCSA_LAST ##[1:1000]
		s_reg.ptr == RTCSA_PTR_RST);
endmodule : rtcsa_port

/* src/rtcsa_pkg.sv */
// package: constants and carrier types for the rtc two-wire slave access port
package rtcsa_pkg;
	// fixed 7-bit slave address, sent as 8'hd0 with the direction bit clear
	localparam logic [6:0] RTCSA_SLAVE_ADDR = 7'h68;
	// number of byte locations behind the pointer
	localparam int RTCSA_NREG = 20;
	// pointer width
	localparam int RTCSA_PW = 5;
	// first and last timekeeping locations
	localparam logic [4:0] RTCSA_SUBSEC = 5'h00;
	localparam logic [4:0] RTCSA_TIME_LAST = 5'h07;
	// last location before the pointer wraps
	localparam logic [4:0] RTCSA_LAST = 5'h13;
	// pointer value after reset
	localparam logic [4:0] RTCSA_PTR_RST = 5'h00;
	// reset value of every register byte
	localparam logic [7:0] RTCSA_BYTE_RST = 8'h00;
	// only value the sub-second byte takes from a write
	localparam logic [7:0] RTCSA_SUBSEC_WR = 8'h00;
	// bits per byte before the acknowledge slot
	localparam logic [3:0] RTCSA_BYTE_BITS = 4'h8;
	// idle level of the bus lines, used as synchroniser reset value
	localparam logic RTCSA_BUS_IDLE = 1'b1;
	// number of timekeeping bytes loaded by the counting core
	localparam int RTCSA_NTIME = 8;

	// slave state machine
	typedef enum logic [3:0] {
		ST_IDLE,    // bus free or waiting for start
		ST_ADDR,    // shifting in slave address
		ST_AACK,    // acknowledging slave address
		ST_WADDR,   // shifting in word address
		ST_WAACK,   // acknowledging word address
		ST_WDATA,   // shifting in write data
		ST_WDACK,   // acknowledging write data
		ST_RDATA,   // shifting out read data
		ST_RACK,    // master acknowledge slot
		ST_IGNORE   // released until next start or stop
	} rtcsa_state_t;

	// whole register space as seen by the user side
	typedef logic [RTCSA_NREG-1:0][7:0] rtcsa_regs_t;

	// time copy from the counting core
	typedef struct packed {
		logic stb;                          // one-cycle update strobe
		logic [RTCSA_NTIME-1:0][7:0] tval;  // bytes for locations 0..7
	} rtcsa_upd_t;

	// open-drain data pin as two signals
	typedef struct packed {
		logic o;   // level driven, always low
		logic oe;  // high while pulling the line low
	} rtcsa_pin_t;
endpackage : rtcsa_pkg

/* src/rtcsa_sync.sv */
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
module rtcsa_sync #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	import rtcsa_pkg::*;

	// both stages of the chain
	typedef struct packed {
		logic [W-1:0] meta;  // first stage, read only by second
		logic [W-1:0] q;     // second stage
	} rtcsa_sync_t;

	rtcsa_sync_t s_reg;
	rtcsa_sync_t s_next;

	// next value of the chain
	always_comb begin
		s_next = s_reg;
		s_next.meta = din;
		s_next.q = s_reg.meta;
	end

	// register the chain, idle-high after reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_reg <= {(2*W){RTCSA_BUS_IDLE}};
		end else begin
			s_reg <= s_next;
		end
	end

	assign dout = s_reg.q;
endmodule : rtcsa_sync

/* dv/rtcsa_master.sv */
// behavioural two-wire bus master facing the access port
`timescale 1ns/1ps
module rtcsa_master (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl_drv,
	output logic sda_drv
);
	// both lines released: the bus starts idle
	initial begin
		scl_drv = 1'h1;
		sda_drv = 1'h1;
	end

	// wait n clock edges, then step just past the last one
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// start from idle, or repeated start
	task automatic start();
		sda_drv = 1'h1;
		tick(8);
		scl_drv = 1'h1;
		tick(10);
		sda_drv = 1'h0;
		tick(10);
		scl_drv = 1'h0;
		tick(8);
	endtask : start

	task automatic stop();
		sda_drv = 1'h0;
		tick(8);
		scl_drv = 1'h1;
		tick(10);
		sda_drv = 1'h1;
		tick(20);
	endtask : stop

	// one pulse per bit, data moved only while low
	task automatic clk_bit(input logic b, output logic s);
		sda_drv = b;
		tick(8);
		scl_drv = 1'h1;
		tick(5);
		// sample mid-high, where the line must be steady
		s = sda_line;
		tick(5);
		scl_drv = 1'h0;
		tick(8);
	endtask : clk_bit

	// eight bits msb first, then the ninth pulse
	task automatic wbyte(input logic [7:0] v, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(v[i], s);
		end
		clk_bit(1'h1, ack_n);
	endtask : wbyte

	// read a byte, leave the last one unacknowledged
	task automatic rbyte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'h1, s);
			v[i] = s;
		end
		clk_bit(last, s);
	endtask : rbyte
endmodule : rtcsa_master

/* dv/rtc_i2c_slave_access_port_tb_top.sv */
// self-checking bench for the rtc two-wire slave access port
`timescale 1ns/1ps
module rtc_i2c_slave_access_port_tb_top;
	import rtcsa_pkg::*;
	logic clk;
	logic reset_n;
	logic scl_i;
	logic sda_i;
	logic scl_drv;
	logic sda_drv;
	rtcsa_pin_t sda_pin;
	rtcsa_upd_t upd;
	logic freeze;
	logic div_reset;
	rtcsa_regs_t regs_o;
	int failures = 0;
	int comparisons = 0;
	int div_count = 0;
	int oe_count = 0;
	int cycles = 0;
	logic ack_n;
	logic [7:0] rd;

	// open-drain data wire with pull-up
	assign sda_i = sda_drv & (sda_pin.o | ~sda_pin.oe);
	assign scl_i = scl_drv;

	rtcsa_port uut (.clk(clk), .reset_n(reset_n), .scl_i(scl_i),
		.sda_i(sda_i), .sda_pin(sda_pin), .upd(upd), .freeze(freeze),
		.div_reset(div_reset), .regs_o(regs_o));

	rtcsa_master m (.clk(clk), .sda_line(sda_i), .scl_drv(scl_drv),
		.sda_drv(sda_drv));

	// 100 MHz clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// count divider pulses and pull-downs, cut a hang short
	always @(posedge clk) begin
		if (div_reset === 1'h1) div_count++;
		if (sda_pin.oe === 1'h1) oe_count++;
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// compare one value and report a mismatch
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one-cycle time update from the counting core
	task automatic pulse_upd(input logic [7:0] base);
		for (int k = 0; k < RTCSA_NTIME; k++) begin
			upd.tval[k] = base + 8'(k);
		end
		upd.stb = 1'h1;
		@(posedge clk);
		#1;
		upd.stb = 1'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse_upd

	// reset state, then a free-running update lands
	task automatic t_reset();
		for (int k = 0; k < RTCSA_NREG; k++) begin
			check("reset byte", regs_o[k], RTCSA_BYTE_RST);
		end
		check("reset freeze", freeze, 1'h0);
		pulse_upd(8'h20);
		check("time copy", regs_o[5], 8'h25);
	endtask : t_reset

	// sequential write across the wrap, update held meanwhile
	task automatic t_write();
		int div_base;
		div_base = div_count;
		m.start();
		m.wbyte(8'hd0, ack_n);
		check("address ack", ack_n, 1'h0);
		m.wbyte(8'h12, ack_n);
		check("word ack", ack_n, 1'h0);
		m.wbyte(8'ha5, ack_n);
		m.wbyte(8'h5a, ack_n);
		m.wbyte(8'h3c, ack_n);
		m.wbyte(8'h59, ack_n);
		check("data ack", ack_n, 1'h0);
		check("freeze on write", freeze, 1'h1);
		pulse_upd(8'h40);
		check("held copy", regs_o[2], 8'h22);
		m.stop();
		check("loc 12h", regs_o[18], 8'ha5);
		check("loc 13h", regs_o[19], 8'h5a);
		check("sub-second", regs_o[0], 8'h00);
		check("wrapped loc 1", regs_o[1], 8'h59);
		check("divider resets", 8'(div_count - div_base), 8'h02);
		check("freeze after stop", freeze, 1'h0);
	endtask : t_write

	// addressed read with repeated start, wrapping, nack at the end
	task automatic t_read();
		m.start();
		m.wbyte(8'hd0, ack_n);
		m.wbyte(8'h12, ack_n);
		m.start();
		m.wbyte(8'hd1, ack_n);
		check("read address ack", ack_n, 1'h0);
		m.rbyte(1'h0, rd);
		check("byte 12h", rd, 8'ha5);
		m.rbyte(1'h0, rd);
		check("byte 13h", rd, 8'h5a);
		m.rbyte(1'h1, rd);
		check("wrapped byte", rd, 8'h00);
		check("released after nack", sda_i, 1'h1);
		m.stop();
	endtask : t_read

	// read from the held pointer; an update mid-read must not land
	task automatic t_current();
		m.start();
		m.wbyte(8'hd1, ack_n);
		m.rbyte(1'h0, rd);
		check("current byte", rd, 8'h59);
		pulse_upd(8'h80);
		check("held on read", regs_o[2], 8'h22);
		m.rbyte(1'h1, rd);
		check("next byte", rd, 8'h22);
		m.stop();
	endtask : t_current

	// pointer leaves the time range and updates resume mid-transfer
	task automatic t_unfreeze();
		m.start();
		m.wbyte(8'hd0, ack_n);
		m.wbyte(8'h07, ack_n);
		m.start();
		// repeated start is no stop: the copy stays held
		pulse_upd(8'h50);
		check("freeze over restart", freeze, 1'h1);
		m.wbyte(8'hd1, ack_n);
		check("freeze in time read", freeze, 1'h1);
		m.rbyte(1'h0, rd);
		check("year byte", rd, 8'h27);
		check("freeze past time", freeze, 1'h0);
		pulse_upd(8'h60);
		check("update resumed", regs_o[7], 8'h67);
		m.rbyte(1'h1, rd);
		check("control byte", rd, 8'h00);
		m.stop();
	endtask : t_unfreeze

	// foreign addresses, three a single bit away, get no answer
	task automatic t_foreign();
		logic [7:0] bad [4] = '{8'ha0, 8'hd2, 8'hd3, 8'h50};
		int oe_base;
		oe_base = oe_count;
		foreach (bad[i]) begin
			m.start();
			m.wbyte(bad[i], ack_n);
			check("foreign ack", ack_n, 1'h1);
			m.wbyte(8'h00, ack_n);
			m.stop();
		end
		check("line left alone", 8'(oe_count - oe_base), 8'h00);
	endtask : t_foreign

	// counts, verdict and end of run
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// main sequence
	initial begin
		reset_n = 1'h0;
		upd = '0;
		repeat (5) @(posedge clk);
		#1;
		reset_n = 1'h1;
		repeat (4) @(posedge clk);
		#1;
		t_reset();
		t_write();
		t_read();
		t_current();
		t_unfreeze();
		t_foreign();
		print_verdict();
	end
endmodule : rtc_i2c_slave_access_port_tb_top
